/* core/tcv_diag_map.sv */
// Serial-ID and diagnostic memory map of the transceiver management block.
// Assumes analog results, flags and counters come from logic on clk.
`timescale 1ns/1ns
`default_nettype none
`include "tcv_regs.svh"
module tcv_diag_map #(
   parameter int unsigned NV_WRITE_CYCLES = `TCV_T_WR_MS * (`TCV_CLK_HZ / 1000),
   parameter int unsigned TO_CYCLES = `TCV_T_TO_MS * (`TCV_LINK_HZ / 1000),
   parameter int unsigned CNT_W = 19
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic link_clk,
   input wire logic arst_n,
   // Two-wire pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Converter results
   input wire logic adc_valid,
   input wire logic [2:0] adc_chan,
   input wire logic [15:0] adc_data,
   // Live status
   input wire logic [15:0] alarm_flags,
   input wire logic [15:0] warn_flags,
   input wire logic [7:0] diag_status,
   input wire logic [7:0] user_status,
   input wire logic [15:0] hours_in,
   // OEM key held in the configuration store
   input wire logic [31:0] oem_key_ref,
   // Control and state
   output logic [7:0] diag_ctrl,
   output logic [7:0] user_ctrl,
   output logic results_ready,
   output logic nv_busy,
   output logic oem_unlocked,
   output logic user_unlocked
);
   localparam int NP = `TCV_ANA_PARAMS;

   typedef struct packed {
      logic [2:0] req_s;
      logic [2:0] stop_s;
      logic [7:0] rdata;
      logic [8*2*NP-1:0] live;
      logic [NP-1:0] fresh;
      logic [NP-1:0] seen;
      logic [7:0] ctrl;
      logic [7:0] uctrl;
      logic [31:0] okey;
      logic [7:0] uset;
      logic [7:0] ukey;
      logic nv_pend;
      logic [CNT_W-1:0] busy_cnt;
   } tcv_map_state_t;

   tcv_map_state_t r_reg, r_next;
   logic [7:0] nvm [0:511];
   logic req_tgl, req_we, req_diag, stop_tgl;
   logic [7:0] req_off, req_wdata;
   logic req_evt, stop_evt, oem_ok, user_ok, any_ok;
   logic mem_we, nv_ok;
   logic [7:0] rd_val;
   logic [3:0] ana_idx;
   logic [1:0] key_idx;
   logic [NP-1:0] fresh_set, fresh_clr;
   tcv_pkg::tcv_region_t rg;

   // ****************************************
   // Region decode
   // ****************************************
   function automatic tcv_pkg::tcv_region_t region(input logic [7:0] a);
      tcv_pkg::tcv_region_t g;
      g = tcv_pkg::RG_RSVD;
      if (a <= `TCV_THR_LAST) begin
         g = tcv_pkg::RG_THRESH;
      end else if (a >= `TCV_CAL_FIRST && a <= `TCV_CAL_LAST) begin
         g = tcv_pkg::RG_CAL;
      end else if (a == `TCV_CKSUM) begin
         g = tcv_pkg::RG_CKSUM;
      end else if (a >= `TCV_ANA_FIRST && a <= `TCV_ANA_LAST) begin
         g = tcv_pkg::RG_ANALOG;
      end else if (a == `TCV_CTRL) begin
         g = tcv_pkg::RG_CTRL;
      end else if (a == `TCV_ALARM_HI || a == `TCV_ALARM_LO) begin
         g = tcv_pkg::RG_ALARM;
      end else if (a == `TCV_WARN_HI || a == `TCV_WARN_LO) begin
         g = tcv_pkg::RG_WARN;
      end else if (a >= `TCV_OKEY_FIRST && a <= `TCV_OKEY_LAST) begin
         g = tcv_pkg::RG_OKEY;
      end else if (a >= `TCV_SCR_FIRST && a <= `TCV_SCR_LAST) begin
         g = tcv_pkg::RG_SCRATCH;
      end else if (a == `TCV_USET) begin
         g = tcv_pkg::RG_USET;
      end else if (a == `TCV_UKEY) begin
         g = tcv_pkg::RG_UKEY;
      end else if (a == `TCV_HOURS_HI || a == `TCV_HOURS_LO) begin
         g = tcv_pkg::RG_HOURS;
      end else if (a == `TCV_FRESH) begin
         g = tcv_pkg::RG_FRESH;
      end else if (a == `TCV_UCTRL) begin
         g = tcv_pkg::RG_UCTRL;
      end
      return g;
   endfunction

   // ****************************************
   // Link-side slave
   // ****************************************
   tcv_link_slave #(
      .TO_CYCLES(TO_CYCLES),
      .CNT_W(CNT_W)
   ) u_link (
      .link_clk(link_clk),
      .arst_n(arst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .req_tgl(req_tgl),
      .req_we(req_we),
      .req_diag(req_diag),
      .req_off(req_off),
      .req_wdata(req_wdata),
      .stop_tgl(stop_tgl),
      .ack_rdata(r_reg.rdata),
      .nv_busy(nv_busy)
   );

   // ****************************************
   // Access control and register behaviour
   // ****************************************
   always_comb begin
      r_next = r_reg;
      r_next.req_s = {r_reg.req_s[1:0], req_tgl};
      r_next.stop_s = {r_reg.stop_s[1:0], stop_tgl};
      // Request fields other than req_diag are stable from the toggle until the next one
      req_evt = r_reg.req_s[1] ^ r_reg.req_s[2];
      stop_evt = r_reg.stop_s[1] ^ r_reg.stop_s[2];
      oem_ok = (r_reg.okey == oem_key_ref);
      user_ok = (r_reg.ukey == r_reg.uset);
      any_ok = oem_ok | user_ok;
      rg = region(req_off);
      ana_idx = 4'(req_off - `TCV_ANA_FIRST);
      key_idx = 2'(req_off - `TCV_OKEY_FIRST);
      nv_ok = 1'h0;
      rd_val = 8'h00;
      fresh_set = '0;
      fresh_clr = '0;
      // Converter results land as they arrive
      if (adc_valid && adc_chan < 3'(NP)) begin
         r_next.live[16*(NP-1-int'(adc_chan)) +: 16] = adc_data;
         fresh_set[adc_chan] = 1'h1;
         r_next.seen[adc_chan] = 1'h1;
      end
      if (!req_diag) begin
         // Vendor bytes open; ID and upper area need the OEM key
         if (req_off >= `TCV_VEND_FIRST && req_off <= `TCV_VEND_LAST) begin
            nv_ok = 1'h1;
         end else begin
            nv_ok = oem_ok;
         end
         rd_val = nvm[{1'h0, req_off}];
      end else begin
         unique case (rg)
            tcv_pkg::RG_THRESH: begin
               nv_ok = oem_ok;
               rd_val = nvm[{1'h1, req_off}];
            end
            tcv_pkg::RG_CAL, tcv_pkg::RG_CKSUM: begin
               nv_ok = oem_ok;
               rd_val = nvm[{1'h1, req_off}];
            end
            tcv_pkg::RG_ANALOG: begin
               rd_val = r_reg.live[8*(2*NP-1-int'(ana_idx)) +: 8];
               if (req_evt && !req_we && ana_idx[0]) begin
                  fresh_clr[ana_idx[3:1]] = 1'h1;
               end
            end
            tcv_pkg::RG_CTRL: begin
               rd_val = (r_reg.ctrl & `TCV_CTRL_WMASK) | (diag_status & ~`TCV_CTRL_WMASK);
               if (req_evt && req_we) begin
                  r_next.ctrl = req_wdata & `TCV_CTRL_WMASK;
               end
            end
            tcv_pkg::RG_ALARM: begin
               // No write path exists for the flag bytes
               rd_val = (req_off == `TCV_ALARM_HI) ? alarm_flags[15:8] : alarm_flags[7:0];
            end
            tcv_pkg::RG_WARN: begin
               // No write path exists for the flag bytes
               rd_val = (req_off == `TCV_WARN_HI) ? warn_flags[15:8] : warn_flags[7:0];
            end
            tcv_pkg::RG_OKEY: begin
               rd_val = r_reg.okey[8*(3-int'(key_idx)) +: 8];
               if (req_evt && req_we) begin
                  r_next.okey[8*(3-int'(key_idx)) +: 8] = req_wdata;
               end
            end
            tcv_pkg::RG_SCRATCH: begin
               nv_ok = any_ok;
               rd_val = any_ok ? nvm[{1'h1, req_off}] : 8'h00;
            end
            tcv_pkg::RG_USET: begin
               rd_val = any_ok ? r_reg.uset : 8'h00;
               if (req_evt && req_we && any_ok) begin
                  r_next.uset = req_wdata;
               end
            end
            tcv_pkg::RG_UKEY: begin
               rd_val = r_reg.ukey;
               if (req_evt && req_we) begin
                  r_next.ukey = req_wdata;
               end
            end
            tcv_pkg::RG_HOURS: begin
               rd_val = (req_off == `TCV_HOURS_HI) ? hours_in[15:8] : hours_in[7:0];
            end
            tcv_pkg::RG_FRESH: begin
               rd_val = 8'(r_reg.fresh);
            end
            tcv_pkg::RG_UCTRL: begin
               rd_val = (r_reg.uctrl & `TCV_UCTRL_WMASK) | (user_status & ~`TCV_UCTRL_WMASK);
               if (req_evt && req_we) begin
                  r_next.uctrl = req_wdata & `TCV_UCTRL_WMASK;
               end
            end
            tcv_pkg::RG_RSVD: begin
               // Reserved bytes read zero and swallow writes
               rd_val = 8'h00;
            end
         endcase
      end
      // Fresh bit clears on reading the result's low byte; a new result wins
      r_next.fresh = (r_reg.fresh & ~fresh_clr) | fresh_set;
      mem_we = req_evt && req_we && nv_ok;
      if (req_evt) begin
         r_next.rdata = rd_val;
      end
      // Write cycle starts at the stop that follows nonvolatile writes
      if (stop_evt && r_reg.nv_pend) begin
         r_next.busy_cnt = CNT_W'(NV_WRITE_CYCLES);
      end else if (r_reg.busy_cnt != '0) begin
         r_next.busy_cnt = r_reg.busy_cnt - CNT_W'(1);
      end
      r_next.nv_pend = (r_reg.nv_pend & ~stop_evt) | mem_we;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
         r_reg.ctrl <= `TCV_CTRL_RST;
         r_reg.uctrl <= `TCV_CTRL_RST;
         r_reg.okey <= `TCV_KEY_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ****************************************
   // Nonvolatile array
   // ****************************************
   // No reset: contents model retained storage, not control state
   always_ff @(posedge clk) begin
      if (mem_we) begin
         nvm[{req_diag, req_off}] <= req_wdata;
      end
   end

   assign diag_ctrl = r_reg.ctrl;
   assign user_ctrl = r_reg.uctrl;
   assign results_ready = &r_reg.seen;
   assign nv_busy = (r_reg.busy_cnt != '0);
   assign oem_unlocked = oem_ok;
   assign user_unlocked = user_ok;
endmodule
`default_nettype wire

/* core/tcv_link_slave.sv */
// Two-wire slave front end running on the link clock.
// Assumes the map answers each request toggle within a few link cycles.
`timescale 1ns/1ns
`default_nettype none
`include "tcv_regs.svh"
module tcv_link_slave #(
   parameter int unsigned TO_CYCLES = `TCV_T_TO_MS * (`TCV_LINK_HZ / 1000),
   parameter int unsigned CNT_W = 19
) (
   // Clock and reset
   input wire logic link_clk,
   input wire logic arst_n,
   // Pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Requests to the map
   output logic req_tgl,
   output logic req_we,
   output logic req_diag,
   output logic [7:0] req_off,
   output logic [7:0] req_wdata,
   output logic stop_tgl,
   // Answers from the map
   input wire logic [7:0] ack_rdata,
   input wire logic nv_busy
);
   typedef struct packed {
      tcv_pkg::tcv_link_st_t st;
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [1:0] busy_s;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic rd;
      logic diag;
      logic have_off;
      logic [7:0] off;
      logic [7:0] roff;
      logic oe;
      logic req;
      logic we;
      logic [7:0] wdata;
      logic wr_any;
      logic stop;
      logic [CNT_W-1:0] to_cnt;
   } tcv_link_state_t;

   tcv_link_state_t r_reg, r_next;
   logic scl_rise, scl_fall, start_c, stop_c;

   // ****************************************
   // Protocol engine
   // ****************************************
   always_comb begin
      r_next = r_reg;
      r_next.scl_s = {r_reg.scl_s[1:0], scl_in};
      r_next.sda_s = {r_reg.sda_s[1:0], sda_in};
      r_next.busy_s = {r_reg.busy_s[0], nv_busy};
      scl_rise = r_reg.scl_s[1] & ~r_reg.scl_s[2];
      scl_fall = ~r_reg.scl_s[1] & r_reg.scl_s[2];
      start_c = r_reg.scl_s[1] & r_reg.scl_s[2] & ~r_reg.sda_s[1] & r_reg.sda_s[2];
      stop_c = r_reg.scl_s[1] & r_reg.scl_s[2] & r_reg.sda_s[1] & ~r_reg.sda_s[2];
      if (r_reg.st != tcv_pkg::LS_IDLE && !r_reg.scl_s[1]) begin
         r_next.to_cnt = r_reg.to_cnt + CNT_W'(1);
      end else begin
         r_next.to_cnt = '0;
      end
      if (start_c) begin
         r_next.st = tcv_pkg::LS_ADDR;
         r_next.bitc = 4'h0;
         r_next.oe = 1'h0;
      end else if (stop_c) begin
         r_next.st = tcv_pkg::LS_IDLE;
         r_next.oe = 1'h0;
         r_next.have_off = 1'h0;
         r_next.wr_any = 1'h0;
         if (r_reg.wr_any) begin
            r_next.stop = ~r_reg.stop;
         end
      end else if (r_reg.to_cnt == CNT_W'(TO_CYCLES - 1)) begin
         // Held-low clock abandons the transfer and frees the data line
         r_next.st = tcv_pkg::LS_IDLE;
         r_next.oe = 1'h0;
      end else begin
         unique case (r_reg.st)
            tcv_pkg::LS_IDLE: begin
            end
            tcv_pkg::LS_ADDR, tcv_pkg::LS_RX: begin
               if (scl_rise) begin
                  r_next.sh = {r_reg.sh[6:0], r_reg.sda_s[1]};
                  r_next.bitc = r_reg.bitc + 4'h1;
               end else if (scl_fall && r_reg.bitc == 4'h8) begin
                  r_next.st = tcv_pkg::LS_ACK;
                  r_next.oe = 1'h1;
                  if (r_reg.st == tcv_pkg::LS_ADDR) begin
                     r_next.rd = r_reg.sh[0];
                     r_next.diag = (r_reg.sh[7:1] == `TCV_DEV_DIAG);
                     if ((r_reg.sh[7:1] != `TCV_DEV_ID && r_reg.sh[7:1] != `TCV_DEV_DIAG)
                         || r_reg.busy_s[1]) begin
                        // No answer while a nonvolatile write is running
                        r_next.st = tcv_pkg::LS_IDLE;
                        r_next.oe = 1'h0;
                     end else if (r_reg.sh[0]) begin
                        r_next.req = ~r_reg.req;
                        r_next.we = 1'h0;
                        r_next.roff = r_reg.off;
                        r_next.off = r_reg.off + 8'h01;
                     end else begin
                        r_next.have_off = 1'h0;
                     end
                  end else if (r_reg.have_off) begin
                     r_next.req = ~r_reg.req;
                     r_next.we = 1'h1;
                     r_next.roff = r_reg.off;
                     r_next.wdata = r_reg.sh;
                     r_next.off = r_reg.off + 8'h01;
                     r_next.wr_any = 1'h1;
                  end else begin
                     r_next.off = r_reg.sh;
                     r_next.have_off = 1'h1;
                  end
               end
            end
            tcv_pkg::LS_ACK: begin
               if (scl_fall) begin
                  r_next.bitc = 4'h0;
                  if (r_reg.rd) begin
                     r_next.st = tcv_pkg::LS_RDATA;
                     r_next.sh = ack_rdata;
                     r_next.oe = ~ack_rdata[7];
                  end else begin
                     r_next.st = tcv_pkg::LS_RX;
                     r_next.oe = 1'h0;
                  end
               end
            end
            tcv_pkg::LS_RDATA: begin
               if (scl_rise) begin
                  r_next.sh = {r_reg.sh[6:0], 1'h0};
                  r_next.bitc = r_reg.bitc + 4'h1;
                  if (r_reg.bitc == 4'h7) begin
                     r_next.st = tcv_pkg::LS_RACK;
                  end
               end else if (scl_fall) begin
                  r_next.oe = ~r_reg.sh[7];
               end
            end
            tcv_pkg::LS_RACK: begin
               if (scl_fall) begin
                  r_next.oe = 1'h0;
               end else if (scl_rise) begin
                  if (r_reg.sda_s[1]) begin
                     r_next.st = tcv_pkg::LS_IDLE;
                  end else begin
                     r_next.st = tcv_pkg::LS_RLOAD;
                     r_next.req = ~r_reg.req;
                     r_next.we = 1'h0;
                     r_next.roff = r_reg.off;
                     r_next.off = r_reg.off + 8'h01;
                  end
               end
            end
            tcv_pkg::LS_RLOAD: begin
               // Half a clock period gives the map time to answer
               if (scl_fall) begin
                  r_next.st = tcv_pkg::LS_RDATA;
                  r_next.bitc = 4'h0;
                  r_next.sh = ack_rdata;
                  r_next.oe = ~ack_rdata[7];
               end
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sda_out = 1'h0;
   assign sda_oe = r_reg.oe;
   assign req_tgl = r_reg.req;
   assign req_we = r_reg.we;
   assign req_diag = r_reg.diag;
   assign req_off = r_reg.roff;
   assign req_wdata = r_reg.wdata;
   assign stop_tgl = r_reg.stop;
endmodule
`default_nettype wire

/* core/tcv_pkg.sv */
// Types shared by the transceiver memory map and its two-wire slave.
// Assumes tcv_regs.svh is on the include path.
package tcv_pkg;
   // Link-side protocol states
   typedef enum logic [2:0] {
      LS_IDLE, LS_ADDR, LS_RX, LS_ACK, LS_RDATA, LS_RACK, LS_RLOAD
   } tcv_link_st_t;
   // Diagnostic map regions
   typedef enum logic [3:0] {
      RG_THRESH, RG_CAL, RG_CKSUM, RG_ANALOG, RG_CTRL, RG_ALARM, RG_WARN,
      RG_OKEY, RG_SCRATCH, RG_USET, RG_UKEY, RG_HOURS, RG_FRESH, RG_UCTRL,
      RG_RSVD
   } tcv_region_t;
endpackage

/* core/tcv_regs.svh */
// Offsets, masks, reset values and timing of the transceiver memory map.
// Assumes inclusion by bare name from the design modules, the checker and the host model.
`ifndef TCV_REGS_SVH
`define TCV_REGS_SVH
// Seven-bit two-wire device addresses
`define TCV_DEV_ID 7'h50
`define TCV_DEV_DIAG 7'h51
// First device address map
`define TCV_VEND_FIRST 8'h60
`define TCV_VEND_LAST 8'h7F
// Diagnostic map
`define TCV_THR_LAST 8'h27
`define TCV_CAL_FIRST 8'h38
`define TCV_CAL_LAST 8'h5B
`define TCV_CKSUM 8'h5F
`define TCV_ANA_FIRST 8'h60
`define TCV_ANA_LAST 8'h69
`define TCV_CTRL 8'h6E
`define TCV_ALARM_HI 8'h70
`define TCV_ALARM_LO 8'h71
`define TCV_WARN_HI 8'h74
`define TCV_WARN_LO 8'h75
`define TCV_OKEY_FIRST 8'h78
`define TCV_OKEY_LAST 8'h7B
`define TCV_SCR_FIRST 8'h80
`define TCV_SCR_LAST 8'hF7
`define TCV_USET 8'hFA
`define TCV_UKEY 8'hFB
`define TCV_HOURS_HI 8'hFC
`define TCV_HOURS_LO 8'hFD
`define TCV_FRESH 8'hFE
`define TCV_UCTRL 8'hFF
// Writable bits of the control bytes and reset values
`define TCV_CTRL_WMASK 8'h48
`define TCV_UCTRL_WMASK 8'h0F
`define TCV_CTRL_RST 8'h00
`define TCV_KEY_RST 32'h0000_0000
// Timing and number of analog results
`define TCV_CLK_HZ 20000000
`define TCV_LINK_HZ 12500000
`define TCV_T_WR_MS 13
`define TCV_T_TO_MS 30
`define TCV_ANA_PARAMS 5
`endif

/* tb/tcv_diag_map_bench.sv */
// Self-checking bench for the transceiver memory map.
// Assumes the host model and checker compile before it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin \
   checks_done++; \
   if ((a) !== (b)) begin \
      num_errors++; \
      $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
   end \
end
module tcv_diag_map_bench;
   typedef struct packed {logic [7:0] dv; logic [7:0] off; logic [7:0] wd; logic [7:0] ex;} tcv_row_t;
   localparam logic [31:0] KEY = 32'h1234_5678;
   int num_errors = 0;
   int checks_done = 0;
   logic clk = 1'b0, link_clk = 1'b0, arst_n = 1'b0, adc_valid = 1'b0;
   logic [2:0] adc_chan = 3'h0;
   logic [15:0] adc_data = 16'h0000, hours_in = 16'hBEEF, alarm = 16'hA55A, warn = 16'h3CC3;
   logic scl, sda_low, sda, sda_oe, sda_out, ready, busy, oem_ok, usr_ok, a, b;
   logic [7:0] diag_ctrl, user_ctrl;
   tcv_row_t rows [13] = '{32'h0127_1111, 32'h0138_3333, 32'h015F_4444, 32'h0000_5555,
      32'h0180_7777, 32'h016E_FFC9, 32'h01FF_FF5F, 32'h0170_00A5, 32'h0175_00C3,
      32'h01FC_00BE, 32'h01FE_001F, 32'h0161_00A0, 32'h01FE_001E};
   assign sda = !sda_low && !(sda_oe && !sda_out);
   always #25 clk = ~clk;
   initial begin
      #13;
      forever #40 link_clk = ~link_clk;
   end
   tcv_host_model tcv_host_model_inst (.scl(scl), .sda_low(sda_low), .sda_in(sda));
   tcv_diag_map #(.NV_WRITE_CYCLES(600), .TO_CYCLES(200)) tcv_diag_map_inst (
      .clk(clk), .link_clk(link_clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .adc_valid(adc_valid), .adc_chan(adc_chan),
      .adc_data(adc_data), .alarm_flags(alarm), .warn_flags(warn),
      .diag_status(8'h81), .user_status(8'h50), .hours_in(hours_in), .oem_key_ref(KEY),
      .diag_ctrl(diag_ctrl), .user_ctrl(user_ctrl), .results_ready(ready), .nv_busy(busy),
      .oem_unlocked(oem_ok), .user_unlocked(usr_ok));
   task automatic idle;
      for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
   endtask
   task automatic wr(input logic dv, input logic [7:0] off, input logic [7:0] d);
      tcv_host_model_inst.wr(dv, off, d);
      idle;
   endtask
   task automatic rd(input logic dv, input logic [7:0] off, input logic [7:0] ex);
      logic [7:0] v;
      tcv_host_model_inst.rd(dv, off, v);
      `CHK(v, ex)
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Span covers about fifty slow-bus transactions
   initial begin
      #5500000;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out;
   end
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK(ready, 1'b0)
      for (int c = 5; c < 11; c++) begin
         @(posedge clk) adc_valid <= 1'b1;
         adc_chan <= 3'(c % 6);
         adc_data <= {8'(8'h10 + c % 6), 8'(8'hA0 + c % 6)};
         @(posedge clk) adc_valid <= 1'b0;
      end
      repeat (3) @(posedge clk);
      `CHK(ready, 1'b1)
      for (int i = 0; i < 4; i++) wr(1'b1, 8'h78 + 8'(i), KEY[31 - 8 * i -: 8]);
      `CHK(oem_ok, 1'b1)
      foreach (rows[i]) begin
         wr(rows[i].dv[0], rows[i].off, rows[i].wd);
         rd(rows[i].dv[0], rows[i].off, rows[i].ex);
      end
      `CHK(diag_ctrl, 8'h48)
      `CHK(user_ctrl, 8'h0F)
      @(posedge clk) hours_in <= 16'hBEF0;
      rd(1'b1, 8'hFD, 8'hF0);
      $display("done: table rows");
      wr(1'b1, 8'h78, 8'h00);
      `CHK(oem_ok, 1'b0)
      wr(1'b1, 8'h27, 8'hEE);
      rd(1'b1, 8'h27, 8'h11);
      wr(1'b1, 8'h5F, 8'hEE);
      rd(1'b1, 8'h5F, 8'h44);
      wr(1'b0, 8'h00, 8'hEE);
      rd(1'b0, 8'h00, 8'h55);
      wr(1'b0, 8'h60, 8'h99);
      rd(1'b0, 8'h60, 8'h99);
      $display("done: key lock");
      wr(1'b1, 8'hFA, 8'h77);
      `CHK(usr_ok, 1'b0)
      rd(1'b1, 8'hFA, 8'h00);
      rd(1'b1, 8'h80, 8'h00);
      wr(1'b1, 8'hFB, 8'h77);
      `CHK(usr_ok, 1'b1)
      rd(1'b1, 8'hFA, 8'h77);
      rd(1'b1, 8'h80, 8'h77);
      $display("done: user key");
      tcv_host_model_inst.wr(1'b1, 8'h81, 8'h5A);
      `CHK(busy, 1'b1)
      tcv_host_model_inst.probe(1'b1, a);
      `CHK(a, 1'b0)
      idle;
      rd(1'b1, 8'h81, 8'h5A);
      tcv_host_model_inst.hang(a, b);
      `CHK(a, 1'b1)
      `CHK(b, 1'b0)
      rd(1'b1, 8'h80, 8'h77);
      $display("done: busy and timeout");
      close_out;
   end
endmodule
`default_nettype wire

/* tb/tcv_diag_map_checker.sv */
// Port-level assertions for the transceiver memory map.
// Assumes it is bound onto tcv_diag_map with matching parameters.
`timescale 1ns/1ns
`default_nettype none
`include "tcv_regs.svh"
module tcv_diag_map_checker #(
   parameter int unsigned NV_WRITE_CYCLES = 50,
   parameter int unsigned TO_CYCLES = 200
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic link_clk,
   input wire logic arst_n,
   // Pins and converter
   input wire logic scl_in,
   input wire logic sda_oe,
   input wire logic adc_valid,
   input wire logic [2:0] adc_chan,
   // State
   input wire logic [7:0] diag_ctrl,
   input wire logic [7:0] user_ctrl,
   input wire logic results_ready,
   input wire logic nv_busy
);
   logic [4:0] seen_reg;
   logic [19:0] busy_cnt_reg;
   logic [19:0] low_cnt_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seen_reg <= 5'h00;
         busy_cnt_reg <= 20'h0_0000;
      end else begin
         if (adc_valid && adc_chan < 3'h5) seen_reg <= seen_reg | (5'h01 << adc_chan);
         busy_cnt_reg <= nv_busy ? busy_cnt_reg + 20'h0_0001 : 20'h0_0000;
      end
   end
   // Saturates so a long hold cannot wrap back under the limit
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) low_cnt_reg <= 20'h0_0000;
      else if (scl_in) low_cnt_reg <= 20'h0_0000;
      else if (low_cnt_reg != 20'hF_FFFF) low_cnt_reg <= low_cnt_reg + 20'h0_0001;
   end
   ready_cause_a: assert property (@(posedge clk) disable iff (!arst_n)
      results_ready |-> seen_reg == 5'h1F) else $error("ready before all results");
   ready_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      !$fell(results_ready)) else $error("ready dropped");
   busy_length_a: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(nv_busy) |-> busy_cnt_reg >= NV_WRITE_CYCLES - 1
      && busy_cnt_reg <= NV_WRITE_CYCLES + 1) else $error("busy length wrong");
   busy_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
      busy_cnt_reg <= NV_WRITE_CYCLES + 1) else $error("busy too long");
   busy_nack_a: assert property (@(posedge clk) disable iff (!arst_n)
      nv_busy |-> !sda_oe) else $error("answer during write cycle");
   busy_frozen_a: assert property (@(posedge clk) disable iff (!arst_n)
      nv_busy |=> $stable(diag_ctrl) && $stable(user_ctrl)) else $error("write while busy");
   ctrl_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
      (diag_ctrl & ~`TCV_CTRL_WMASK) == 8'h00) else $error("control bit outside mask");
   uctrl_mask_a: assert property (@(posedge clk) disable iff (!arst_n)
      (user_ctrl & ~`TCV_UCTRL_WMASK) == 8'h00) else $error("user bit outside mask");
   hold_release_a: assert property (@(posedge link_clk) disable iff (!arst_n)
      low_cnt_reg > TO_CYCLES + 6 |-> !sda_oe) else $error("data held after timeout");
   cover property (@(posedge clk) disable iff (!arst_n) $rose(nv_busy));
   cover property (@(posedge clk) disable iff (!arst_n) $rose(results_ready));
   cover property (@(posedge link_clk) disable iff (!arst_n) $rose(sda_oe));
endmodule
bind tcv_diag_map tcv_diag_map_checker #(
   .NV_WRITE_CYCLES(NV_WRITE_CYCLES), .TO_CYCLES(TO_CYCLES)
) tcv_diag_map_checker_inst (
   .clk(clk), .link_clk(link_clk), .arst_n(arst_n), .scl_in(scl_in), .sda_oe(sda_oe),
   .adc_valid(adc_valid), .adc_chan(adc_chan), .diag_ctrl(diag_ctrl),
   .user_ctrl(user_ctrl), .results_ready(results_ready), .nv_busy(nv_busy)
);
`default_nettype wire

/* tb/tcv_host_model.sv */
// Host two-wire bus controller model.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
`include "tcv_regs.svh"
module tcv_host_model #(
   parameter int Q = 625
) (
   // Bus
   output logic scl,
   output logic sda_low,
   input wire logic sda_in
);
   // Clock stands high and data is released between frames
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   function automatic logic [7:0] adr(input logic dv, input logic r);
      return {dv ? `TCV_DEV_DIAG : `TCV_DEV_ID, r};
   endfunction
   task automatic bo(input logic b);
      sda_low = !b;
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
      #Q;
   endtask
   task automatic bi(output logic b);
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q b = sda_in;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic st;
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
      #Q;
   endtask
   task automatic sp;
      sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask
   task automatic tx(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) bo(v[i]);
      bi(b);
      ack = !b;
   endtask
   // Offsets passed here never name reserved bytes
   task automatic wr(input logic dv, input logic [7:0] off, input logic [7:0] d);
      logic a;
      st;
      tx(adr(dv, 1'b0), a);
      tx(off, a);
      tx(d, a);
      sp;
   endtask
   task automatic rd(input logic dv, input logic [7:0] off, output logic [7:0] v);
      logic a;
      st;
      tx(adr(dv, 1'b0), a);
      tx(off, a);
      st;
      tx(adr(dv, 1'b1), a);
      for (int i = 7; i >= 0; i--) bi(v[i]);
      bo(1'b1);
      sp;
   endtask
   task automatic probe(input logic dv, output logic ack);
      st;
      tx(adr(dv, 1'b0), ack);
      sp;
   endtask
   // Clock held low while the slave owns the acknowledge slot
   task automatic hang(output logic early, output logic late);
      logic [7:0] v;
      logic b;
      v = adr(1'b1, 1'b0);
      st;
      for (int i = 7; i >= 0; i--) bo(v[i]);
      sda_low = 1'b0;
      #Q early = !sda_in;
      #30000 late = !sda_in;
      bi(b);
      sp;
   endtask
endmodule
`default_nettype wire
